//--- logic/spf_pkg.sv
`default_nettype none
package spf_pkg;

  // -----------------------------------------------------------------
  // register map (byte addresses on the axi4-lite bus)
  // -----------------------------------------------------------------
  localparam logic [3:0] SPF_OFS_STATUS  = 4'h0; // serial_status
  localparam logic [3:0] SPF_OFS_CONTROL = 4'h4; // serial_control
  localparam logic [3:0] SPF_OFS_TX_HOLD = 4'h8; // tx_holding_reg
  localparam logic [3:0] SPF_OFS_RX_HOLD = 4'hc; // rx_holding_reg

  // -----------------------------------------------------------------
  // serial_status fields and reset value
  // -----------------------------------------------------------------
  localparam int unsigned SPF_BIT_TX_BUFFER_EMPTY_FLAG = 7; // tx_buffer_empty_flag
  localparam int unsigned SPF_BIT_RX_BUFFER_FULL_FLAG = 6; // rx_buffer_full_flag
  localparam int unsigned SPF_BIT_OVR  = 5; // overrun_flag
  localparam int unsigned SPF_BIT_FRM  = 4; // framing_error_flag
  localparam int unsigned SPF_BIT_PAR  = 3; // parity_error_flag
  localparam int unsigned SPF_BIT_TRANSMIT_END_FLAG = 2; // transmit_end_flag
  localparam int unsigned SPF_BIT_RX_MULTIPROC_BIT = 1; // rx_multiproc_bit
  localparam int unsigned SPF_BIT_TX_MULTIPROC_BIT = 0; // tx_multiproc_bit
  localparam logic [7:0]  SPF_STATUS_RST = 8'h84;

  // -----------------------------------------------------------------
  // serial_control fields and reset value
  // -----------------------------------------------------------------
  localparam int unsigned SPF_CTL_TE   = 0; // transmit_enable_bit
  localparam int unsigned SPF_CTL_RE   = 1; // receive_enable_bit
  localparam int unsigned SPF_CTL_SYNC = 2; // synchronous mode
  localparam int unsigned SPF_CTL_PEN  = 3; // parity enable
  localparam int unsigned SPF_CTL_PM   = 4; // parity_mode_select, 1 = odd
  localparam int unsigned SPF_CTL_MP   = 5; // multiprocessor format
  localparam logic [7:0]  SPF_CONTROL_RST = 8'h00;
  localparam logic [7:0]  SPF_CONTROL_MASK = 8'h3f;

  // -----------------------------------------------------------------
  // bus answers
  // -----------------------------------------------------------------
  localparam logic [1:0] SPF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SPF_RESP_SLVERR = 2'h2;

  // end-of-character report from the receive shifter
  typedef struct packed {
    logic       valid;      // one-cycle pulse, character complete
    logic [7:0] data;       // contents of rx_shift_reg
    logic       stop_bit;   // first stop bit as sampled
    logic       parity_bit; // received parity bit
    logic       mpb;        // received multiprocessor bit
  } spf_rx_evt_s;

endpackage
`default_nettype wire

//--- logic/spf_status.sv
`default_nettype none
module spf_status (
  input  wire logic                 aclk,           // system clock, 200 MHz
  input  wire logic                 aresetn,        // synchronous reset, active low
  input  wire logic                 lowpower_entry, // level, standby/watch/sub modes
  // axi4-lite slave
  input  wire logic [3:0]           awaddr,         // write address
  input  wire logic                 awvalid,        // write address valid
  output logic                      awready,        // write address ready
  input  wire logic [31:0]          wdata,          // write data
  input  wire logic [3:0]           wstrb,          // byte enables
  input  wire logic                 wvalid,         // write data valid
  output logic                      wready,         // write data ready
  output logic [1:0]                bresp,          // write response
  output logic                      bvalid,         // write response valid
  input  wire logic                 bready,         // write response ready
  input  wire logic [3:0]           araddr,         // read address
  input  wire logic                 arvalid,        // read address valid
  output logic                      arready,        // read address ready
  output logic [31:0]               rdata,          // read data
  output logic [1:0]                rresp,          // read response
  output logic                      rvalid,         // read data valid
  input  wire logic                 rready,         // read data ready
  // transmit shifter side
  input  wire logic                 tx_shift_idle,  // tx_shift_reg can take a byte
  input  wire logic                 tx_last_bit,    // pulse, last bit of character sent
  output logic                      tx_load,        // pulse, holding moved to shifter
  output logic [7:0]                tx_data,        // tx_holding_reg contents
  output logic                      tx_mpb,         // tx_multiproc_bit to append
  output logic                      tx_halt,        // transmit stalled by rx error
  output logic [7:0]                ctl_out,        // serial_control to shifters
  // receive shifter side
  input  wire spf_pkg::spf_rx_evt_s rx_evt,         // end-of-character report
  output logic                      rx_halt         // reception stalled by error
);

  // -----------------------------------------------------------------
  // storage
  // -----------------------------------------------------------------
  logic [7:0]  status_ff;   // serial_status
  logic [7:0]  nxt_status;  // its next value
  logic [7:3]  arm_ff;      // flag seen as 1 by a status read
  logic [7:3]  nxt_arm;     // its next value
  logic [7:0]  control_ff;  // serial_control
  logic [7:0]  tx_hold_ff;  // tx_holding_reg
  logic [7:0]  rx_hold_ff;  // rx_holding_reg

  // bus channel state
  logic        aw_got_ff;   // write address latched
  logic [3:0]  awaddr_ff;   // latched write address
  logic        w_got_ff;    // write data latched
  logic [31:0] wdata_ff;    // latched write data
  logic [3:0]  wstrb_ff;    // latched byte enables
  logic        bvalid_ff;   // write answer pending
  logic [1:0]  bresp_ff;    // write answer code
  logic        rvalid_ff;   // read answer pending
  logic [31:0] rdata_ff;    // read answer data
  logic [1:0]  rresp_ff;    // read answer code

  // -----------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------
  logic wr_fire;     // both write halves held, perform write now
  logic wr_lane0;    // low byte lane enabled
  logic wr_status;   // write to serial_status
  logic wr_control;  // write to serial_control
  logic wr_tx_hold;  // write to tx_holding_reg
  logic ar_fire;     // read address taken this edge
  logic rd_status;   // read of serial_status
  logic rd_rx_hold;  // read of rx_holding_reg
  logic te;          // transmit enabled
  logic re;          // receive enabled
  logic sync_mode;   // synchronous mode
  logic rx_err_any;  // any receive error flag up
  logic rx_take;     // character report is accepted
  logic rx_frm_err;  // framing error in this character
  logic rx_par_err;  // parity error in this character

  assign wr_fire    = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign wr_lane0   = wstrb_ff[0];
  assign wr_status  = wr_fire & wr_lane0 & (awaddr_ff[3:2] == spf_pkg::SPF_OFS_STATUS[3:2]);
  assign wr_control = wr_fire & wr_lane0 & (awaddr_ff[3:2] == spf_pkg::SPF_OFS_CONTROL[3:2]);
  assign wr_tx_hold = wr_fire & wr_lane0 & (awaddr_ff[3:2] == spf_pkg::SPF_OFS_TX_HOLD[3:2]);
  assign ar_fire    = arvalid & ~rvalid_ff;
  assign rd_status  = ar_fire & (araddr[3:2] == spf_pkg::SPF_OFS_STATUS[3:2]);
  assign rd_rx_hold = ar_fire & (araddr[3:2] == spf_pkg::SPF_OFS_RX_HOLD[3:2]);

  assign te        = control_ff[spf_pkg::SPF_CTL_TE];
  assign re        = control_ff[spf_pkg::SPF_CTL_RE];
  assign sync_mode = control_ff[spf_pkg::SPF_CTL_SYNC];

  // any error flag stops the receiver, and the transmitter in sync mode
  assign rx_err_any = status_ff[spf_pkg::SPF_BIT_OVR] | status_ff[spf_pkg::SPF_BIT_FRM]
                    | status_ff[spf_pkg::SPF_BIT_PAR];
  assign rx_halt    = rx_err_any;
  assign tx_halt    = rx_err_any & sync_mode;

  // a report is dropped while disabled or halted, so nothing moves
  assign rx_take    = rx_evt.valid & re & ~rx_err_any;
  // no stop or parity bit exists on a synchronous frame
  assign rx_frm_err = ~sync_mode & ~rx_evt.stop_bit;
  assign rx_par_err = ~sync_mode & control_ff[spf_pkg::SPF_CTL_PEN]
                    & (^rx_evt.data ^ rx_evt.parity_bit ^ control_ff[spf_pkg::SPF_CTL_PM]);

  // handshake out to the transmit shifter
  assign tx_load = ~status_ff[spf_pkg::SPF_BIT_TX_BUFFER_EMPTY_FLAG] & te & tx_shift_idle & ~tx_halt;
  assign tx_data = tx_hold_ff;
  assign tx_mpb  = status_ff[spf_pkg::SPF_BIT_TX_MULTIPROC_BIT];
  assign ctl_out = control_ff;

  // -----------------------------------------------------------------
  // flag next-state: every set term is or-ed after the clear terms
  // -----------------------------------------------------------------
  always_comb begin
    logic [7:3] clr;     // armed flag written with 0
    logic       tx_buffer_empty_flag_clr;
    clr      = '0;
    tx_buffer_empty_flag_clr = 1'b0;
    nxt_status = status_ff;
    if (wr_status) begin
      clr = arm_ff & ~wdata_ff[7:3];
    end
    // tx empty: cleared by armed zero or a new byte
    tx_buffer_empty_flag_clr = clr[spf_pkg::SPF_BIT_TX_BUFFER_EMPTY_FLAG] | wr_tx_hold;
    if (tx_buffer_empty_flag_clr) begin
      nxt_status[spf_pkg::SPF_BIT_TX_BUFFER_EMPTY_FLAG] = 1'b0;
      nxt_status[spf_pkg::SPF_BIT_TRANSMIT_END_FLAG] = 1'b0;
    end
    if (tx_load | ~te) begin
      nxt_status[spf_pkg::SPF_BIT_TX_BUFFER_EMPTY_FLAG] = 1'b1;
    end
    // transmit end follows the empty flag at the last bit
    if ((tx_last_bit & status_ff[spf_pkg::SPF_BIT_TX_BUFFER_EMPTY_FLAG]) | ~te) begin
      nxt_status[spf_pkg::SPF_BIT_TRANSMIT_END_FLAG] = 1'b1;
    end
    // rx full: cleared by armed zero or data read
    if (clr[spf_pkg::SPF_BIT_RX_BUFFER_FULL_FLAG] | rd_rx_hold) begin
      nxt_status[spf_pkg::SPF_BIT_RX_BUFFER_FULL_FLAG] = 1'b0;
    end
    for (int i = spf_pkg::SPF_BIT_PAR; i <= spf_pkg::SPF_BIT_OVR; i++) begin
      if (clr[i]) begin
        nxt_status[i] = 1'b0;
      end
    end
    if (rx_take) begin
      if (status_ff[spf_pkg::SPF_BIT_RX_BUFFER_FULL_FLAG]) begin
        nxt_status[spf_pkg::SPF_BIT_OVR] = 1'b1;
      end else begin
        if (rx_frm_err) begin
          nxt_status[spf_pkg::SPF_BIT_FRM] = 1'b1;
        end
        if (rx_par_err) begin
          nxt_status[spf_pkg::SPF_BIT_PAR] = 1'b1;
        end
        if (~rx_frm_err & ~rx_par_err) begin
          nxt_status[spf_pkg::SPF_BIT_RX_BUFFER_FULL_FLAG] = 1'b1;
        end
      end
      // multiprocessor bit only exists in async multiprocessor format
      if (~sync_mode & control_ff[spf_pkg::SPF_CTL_MP]) begin
        nxt_status[spf_pkg::SPF_BIT_RX_MULTIPROC_BIT] = rx_evt.mpb;
      end
    end
    if (wr_status) begin
      nxt_status[spf_pkg::SPF_BIT_TX_MULTIPROC_BIT] = wdata_ff[spf_pkg::SPF_BIT_TX_MULTIPROC_BIT];
    end
    // arm follows what software saw, and drops once the flag is low
    nxt_arm = (arm_ff | (rd_status ? status_ff[7:3] : 5'h00)) & nxt_status[7:3];
  end

  // -----------------------------------------------------------------
  // status register and arm bits
  // -----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || lowpower_entry) begin
      status_ff <= spf_pkg::SPF_STATUS_RST;
      arm_ff    <= 5'h00;
    end else begin
      status_ff <= nxt_status;
      arm_ff    <= nxt_arm;
    end
  end

  // control register, written whole from the low byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control_ff <= spf_pkg::SPF_CONTROL_RST;
    end else if (wr_control) begin
      control_ff <= wdata_ff[7:0] & spf_pkg::SPF_CONTROL_MASK;
    end
  end

  // transmit holding register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold_ff <= 8'h00;
    end else if (wr_tx_hold) begin
      tx_hold_ff <= wdata_ff[7:0];
    end
  end

  // receive holding register: an overrun never overwrites it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_hold_ff <= 8'h00;
    end else if (rx_take & ~status_ff[spf_pkg::SPF_BIT_RX_BUFFER_FULL_FLAG]) begin
      rx_hold_ff <= rx_evt.data;
    end
  end

  // -----------------------------------------------------------------
  // axi4-lite write channels: address and data taken in any order
  // -----------------------------------------------------------------
  assign awready = ~aw_got_ff & ~bvalid_ff;
  assign wready  = ~w_got_ff & ~bvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      awaddr_ff <= 4'h0;
    end else if (awvalid & awready) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= awaddr;
    end else if (wr_fire) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (wvalid & wready) begin
      w_got_ff <= 1'b1;
      wdata_ff <= wdata;
      wstrb_ff <= wstrb;
    end else if (wr_fire) begin
      w_got_ff <= 1'b0;
    end
  end

  // write answer; rx holding is read-only, so a write there errs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= spf_pkg::SPF_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (awaddr_ff[3:2] == spf_pkg::SPF_OFS_RX_HOLD[3:2]) ? spf_pkg::SPF_RESP_SLVERR
                                                                     : spf_pkg::SPF_RESP_OKAY;
    end else if (bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // axi4-lite read channel: one cycle from address to data
  // -----------------------------------------------------------------
  assign arready = ~rvalid_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= spf_pkg::SPF_RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= spf_pkg::SPF_RESP_OKAY;
      case (araddr[3:2])
        spf_pkg::SPF_OFS_STATUS[3:2]:  rdata_ff <= {24'h00_0000, status_ff};
        spf_pkg::SPF_OFS_CONTROL[3:2]: rdata_ff <= {24'h00_0000, control_ff};
        spf_pkg::SPF_OFS_TX_HOLD[3:2]: rdata_ff <= {24'h00_0000, tx_hold_ff};
        spf_pkg::SPF_OFS_RX_HOLD[3:2]: rdata_ff <= {24'h00_0000, rx_hold_ff};
        default: begin
          rdata_ff <= 32'h0000_0000;
          rresp_ff <= spf_pkg::SPF_RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  reset_value_a: assert property (@(posedge aclk) $rose(aresetn) |-> status_ff == 8'h84)
    else $error("status not 84 after reset");

  overrun_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(status_ff[5]) |-> $past(rx_take & status_ff[6]))
    else $error("overrun rose without full buffer report");

  transmit_end_flag_cause_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(status_ff[2]) |-> $past((tx_last_bit & status_ff[7]) | ~te | lowpower_entry))
    else $error("transmit end rose without cause");

  tx_buffer_empty_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_load |=> status_ff[7] && $past(tx_hold_ff) == tx_hold_ff)
    else $error("empty flag not set after load");

  te_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ~te |=> status_ff[7] & status_ff[2])
    else $error("disable did not set empty and end");

  rx_buffer_full_flag_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_rx_hold & ~rx_take & ~lowpower_entry |=> ~status_ff[6])
    else $error("data read left full flag set");

  overrun_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_take & status_ff[6] |=> $stable(rx_hold_ff))
    else $error("overrun overwrote held byte");

  halt_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_evt.valid & rx_err_any |=> $stable(rx_hold_ff) ##1 $stable(rx_hold_ff) || rx_take)
    else $error("report taken while halted");

  frame_store_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rx_take & ~status_ff[6] & rx_frm_err & ~lowpower_entry |=> status_ff[4] & ~status_ff[6]
      & rx_hold_ff == $past(rx_evt.data))
    else $error("framing error handling wrong");

  sync_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    sync_mode & rx_err_any |-> ~tx_load)
    else $error("sync transmit ran during error");

  clear_armed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(status_ff[5]) |-> $past(arm_ff[5] | lowpower_entry))
    else $error("overrun cleared without arming read");

  overrun_cov: cover property (@(posedge aclk) disable iff (!aresetn) rx_take & status_ff[6]);
  clear_cov:   cover property (@(posedge aclk) disable iff (!aresetn) wr_status & (|(arm_ff & ~wdata_ff[7:3])));
  txload_cov:  cover property (@(posedge aclk) disable iff (!aresetn) tx_load ##[1:20] tx_last_bit);

endmodule
`default_nettype wire

//--- tb/spf_line_model.sv
`default_nettype none
module spf_line_model (
  input  wire logic            aclk,          // system clock
  input  wire logic            aresetn,       // synchronous reset, active low
  input  wire logic            tx_load,       // byte handed to the shifter
  output logic                 tx_shift_idle, // shifter can take a byte
  output logic                 tx_last_bit,   // pulse, last bit of character out
  output spf_pkg::spf_rx_evt_s rx_evt         // end-of-character report
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_ff; // bit cells left in the character

  initial begin
    tx_shift_idle = 1'b1;
    tx_last_bit   = 1'b0;
    cnt_ff        = 8'h00;
    rx_evt        = '0;
  end

  // -------------------------------------------------------------
  // transmit shifter: 40 cycles per character so tx_buffer_empty_flag can be seen low
  // -------------------------------------------------------------
  always @(posedge aclk) begin
    tx_last_bit <= 1'b0;
    if (!aresetn) begin
      tx_shift_idle <= 1'b1;
      cnt_ff        <= 8'h00;
    end else if (tx_load) begin // new character starts
      tx_shift_idle <= 1'b0;
      cnt_ff        <= 8'h28;
    end else if (!tx_shift_idle) begin
      cnt_ff <= cnt_ff - 8'h01;
      if (cnt_ff == 8'h01) begin // last bit leaves the line
        tx_last_bit   <= 1'b1;
        tx_shift_idle <= 1'b1;
      end
    end
  end

  // one-cycle report; released fields show the inverse so stale data never looks valid
  task automatic send(input logic [7:0] d, input logic stop, input logic par, input logic mpb);
    @(posedge aclk);
    rx_evt <= '{valid: 1'b1, data: d, stop_bit: stop, parity_bit: par, mpb: mpb};
    @(posedge aclk);
    rx_evt <= '{valid: 1'b0, data: ~d, stop_bit: ~stop, parity_bit: ~par, mpb: ~mpb};
  endtask
endmodule
`default_nettype wire

//--- tb/serial_port_status_flags_tb_top.sv
`default_nettype none
module serial_port_status_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ST = spf_pkg::SPF_OFS_STATUS;  // status word
  localparam logic [3:0] CT = spf_pkg::SPF_OFS_CONTROL; // control word
  localparam logic [3:0] TX = spf_pkg::SPF_OFS_TX_HOLD; // transmit holding
  localparam logic [3:0] RX = spf_pkg::SPF_OFS_RX_HOLD; // receive holding
  logic aclk, aresetn, lowpower_entry, awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic tx_shift_idle, tx_last_bit, tx_load, tx_mpb, tx_halt, rx_halt;
  logic [3:0]  awaddr, araddr;  // bus addresses
  logic [31:0] wdata, rdata;    // bus data
  logic [1:0]  bresp, rresp, r; // answers
  logic [7:0]  tx_data, ctl_out, d, p, g;
  spf_pkg::spf_rx_evt_s rx_evt; // from the line model
  int fail_count = 0, n_compared = 0, cyc = 0, seed = 32'had5033db;

  spf_status dut (.aclk, .aresetn, .lowpower_entry, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready(1'b1), .tx_shift_idle, .tx_last_bit, .tx_load, .tx_data, .tx_mpb, .tx_halt,
    .ctl_out, .rx_evt, .rx_halt);
  spf_line_model far (.aclk, .aresetn, .tx_load, .tx_shift_idle, .tx_last_bit, .rx_evt);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // hang guard: the whole run needs well under 5000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // handshakes are judged at the rising edge with pre-edge values, so each half
  // is released only after the edge that took it, and the answer is read there
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic tb;
    tb = 1'b0;
    awaddr <= a; wdata <= {24'h0, v}; awvalid <= 1'b1; wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid & awready) awvalid <= 1'b0;
      if (wvalid & wready) wvalid <= 1'b0;
      tb = bvalid;
      r = bresp;
    end while (!tb);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    logic tv;
    tv = 1'b0;
    araddr <= a; arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid & arready) arvalid <= 1'b0;
      tv = rvalid;
      v = rdata[7:0];
    end while (!tv);
  endtask

  task automatic st(input logic [7:0] e); rd(ST, g); chk(g, e); endtask
  task automatic clr(input logic [7:0] v); rd(ST, g); wr(ST, v); endtask // read arms, then write

  initial begin
    aresetn = 1'b0; lowpower_entry = 1'b0; awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0;
    awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    st(8'h84);
    rd(CT, g); chk(g, 8'h00);
    wr(CT, 8'h03); d = 8'($random(seed)); p = 8'($random(seed));
    wr(TX, d); wr(TX, p); st(8'h00);
    chk(tx_data, p);
    repeat (100) @(posedge aclk);
    st(8'h84);
    $display("transmit flags done");
    d = 8'($random(seed)); far.send(d, 1'b1, 1'b0, 1'b0);
    wr(ST, 8'hbe); st(8'hc4);
    wr(ST, 8'hbe); st(8'h84);
    d = 8'($random(seed)); far.send(d, 1'b1, 1'b0, 1'b0);
    rd(RX, g); chk(g, d); st(8'h84);
    d = 8'($random(seed)); p = 8'($random(seed));
    far.send(d, 1'b1, 1'b0, 1'b0); far.send(p, 1'b1, 1'b0, 1'b0);
    st(8'he4); chk(rx_halt, 8'h01);
    far.send(~d, 1'b1, 1'b0, 1'b0); rd(RX, g); chk(g, d);
    wr(CT, 8'h05); chk(tx_halt, 8'h01); st(8'ha4);
    clr(8'hde); st(8'h84); wr(CT, 8'h03);
    d = 8'($random(seed)); far.send(d, 1'b0, 1'b0, 1'b0);
    st(8'h94); chk(rx_halt, 8'h01);
    rd(RX, g); chk(g, d); clr(8'hee);
    $display("overrun and framing done");
    for (int m = 0; m < 2; m++) begin // even then odd parity
      wr(CT, {3'h0, m[0], 4'hb}); d = 8'($random(seed));
      far.send(d, 1'b1, ^d ^ m[0], 1'b0); st(8'hc4); rd(RX, g); chk(g, d);
      d = 8'($random(seed)); far.send(d, 1'b1, ~(^d ^ m[0]), 1'b0); st(8'h8c);
      far.send(~d, 1'b1, ^d ^ m[0], 1'b0); rd(RX, g); chk(g, d); clr(8'hf6);
    end
    $display("parity done");
    wr(CT, 8'h23); far.send(d, 1'b1, 1'b0, 1'b1); st(8'hc6);
    rd(RX, g); wr(CT, 8'h21); wr(ST, 8'hfd); st(8'h87); chk(tx_mpb, 8'h01);
    wr(CT, 8'h01); wr(TX, d); wr(TX, p); wr(CT, 8'h00); st(8'h87);
    lowpower_entry <= 1'b1; repeat (2) @(posedge aclk); lowpower_entry <= 1'b0;
    st(8'h84);
    wr(RX, 8'h00); chk(r, spf_pkg::SPF_RESP_SLVERR);
    $display("mode and misc done");
    wrap_up();
  end
endmodule
`default_nettype wire
